// file: rtl/iocr_pkg.sv
/*
 * Constants, register map, code tables and derived timing for the
 * output configuration register bank of an inertial sensor unit.
 * Assumes a 250 MHz core clock and an SPI master on the pins.
 */
package iocr_pkg;

	// ---------------------------------------------------------------
	// link framing
	// ---------------------------------------------------------------
	localparam int WORD_W = 16;
	localparam int ADDR_W = 7;
	localparam int BYTE_W = 8;
	localparam int CNT_W = 5;
	localparam logic [CNT_W-1:0] LAST_BIT = 5'h0f;

	// ---------------------------------------------------------------
	// register offsets
	// ---------------------------------------------------------------
	localparam logic [ADDR_W-1:0] ADDR_RATE = 7'h37;
	localparam logic [ADDR_W-1:0] ADDR_FILT = 7'h38;
	localparam logic [ADDR_W-1:0] ADDR_RANGE = 7'h39;
	localparam logic [ADDR_W-1:0] ADDR_DIAG = 7'h3c;
	localparam logic [ADDR_W-1:0] ADDR_MAP_HI = 7'h74;
	localparam logic [ADDR_W-1:0] ADDR_MAP_LO = 7'h75;
	localparam int DIAG_OVER_BIT = 4;

	// ---------------------------------------------------------------
	// reset values
	// ---------------------------------------------------------------
	localparam logic [WORD_W-1:0] RST_RATE = 16'h0101;
	localparam logic [WORD_W-1:0] RST_FILT = 16'h0206;
	localparam logic [WORD_W-1:0] RST_RANGE = 16'h0206;
	localparam logic [WORD_W-1:0] RST_MAP = 16'h0000;

	// ---------------------------------------------------------------
	// timing: base sample period 200 Hz
	// ---------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 4;
	localparam int BASE_PERIOD_NS = 5000000;
	localparam int BASE_CYCLES = BASE_PERIOD_NS / CLK_PERIOD_NS;

	// ---------------------------------------------------------------
	// rate sample: raw lsb is 1/400 dps
	// ---------------------------------------------------------------
	localparam int RAW_W = 20;
	typedef logic signed [RAW_W-1:0] iocr_raw_t;

	// rate code to divider of the 200 Hz base, zero when undefined
	function automatic logic [BYTE_W-1:0] rate_div(logic [BYTE_W-1:0] c);
		unique case (c)
			8'h01: rate_div = 8'h01;
			8'h02: rate_div = 8'h02;
			8'h03: rate_div = 8'h04;
			8'h04: rate_div = 8'h08;
			8'h05: rate_div = 8'h0a;
			8'h06: rate_div = 8'h14;
			8'h07: rate_div = 8'h28;
			8'h08: rate_div = 8'h32;
			8'h09: rate_div = 8'h64;
			8'h10: rate_div = 8'hc8;
			default: rate_div = 8'h00;
		endcase
	endfunction : rate_div

	// range code to right shift of raw units, 7 when undefined
	function automatic logic [2:0] range_shift(logic [BYTE_W-1:0] c);
		unique case (c)
			8'h01: range_shift = 3'h0;
			8'h02: range_shift = 3'h1;
			8'h04: range_shift = 3'h2;
			8'h08: range_shift = 3'h3;
			8'h10: range_shift = 3'h4;
			default: range_shift = 3'h7;
		endcase
	endfunction : range_shift

	// signal (clip) limit in raw units: 80/160/200/400/600 dps
	function automatic iocr_raw_t sig_lim(logic [2:0] s);
		unique case (s)
			3'h0: sig_lim = 20'sh07d00;
			3'h1: sig_lim = 20'sh0fa00;
			3'h2: sig_lim = 20'sh13880;
			3'h3: sig_lim = 20'sh27100;
			default: sig_lim = 20'sh3a980;
		endcase
	endfunction : sig_lim

	// over-range limit in raw units: 62.5/125/220/440/660 dps
	function automatic iocr_raw_t ovr_lim(logic [2:0] s);
		unique case (s)
			3'h0: ovr_lim = 20'sh061a8;
			3'h1: ovr_lim = 20'sh0c350;
			3'h2: ovr_lim = 20'sh157c0;
			3'h3: ovr_lim = 20'sh2af80;
			default: ovr_lim = 20'sh40740;
		endcase
	endfunction : ovr_lim

	// defined filter codes: off, Bartlett, Butterworth
	function automatic logic filt_ok(logic [BYTE_W-1:0] c);
		unique case (c)
			8'h00, 8'h03, 8'h04, 8'h05, 8'h06: filt_ok = 1'b1;
			8'h30, 8'h40, 8'h50, 8'h60: filt_ok = 1'b1;
			default: filt_ok = 1'b0;
		endcase
	endfunction : filt_ok

endpackage : iocr_pkg

// file: rtl/iocr_sync.sv
/*
 * Two-stage synchroniser for a vector of asynchronous levels.
 * Assumes the caller reads only the second stage.
 */
module iocr_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] INIT = '0
) (
	// clock, reset, enable
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic en_i,
	// data
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} iocr_sync_t;

	iocr_sync_t st;
	iocr_sync_t next_st;

	// shift the level through two stages
	always_comb begin
		next_st = st;
		if (en_i) begin
			next_st.s1 = d_i;
			next_st.s2 = st.s1;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st <= {INIT, INIT};
		end else begin
			st <= next_st;
		end
	end

	assign q_o = st.s2;
endmodule : iocr_sync

// file: rtl/iocr_regs.sv
/*
 * Output configuration register bank behind an SPI slave port:
 * output rate with data-ready pacing, rate range with scaling,
 * clipping and over-range, filter select and axis orientation.
 * Assumes SPI pins arrive asynchronously and rate samples arrive
 * on core_clk_i with a valid strobe.
 */
module iocr_regs
	import iocr_pkg::*;
#(
	parameter int BASE_CYC = iocr_pkg::BASE_CYCLES,
	parameter logic [iocr_pkg::WORD_W-1:0] MAP_RESET = iocr_pkg::RST_MAP
) (
	// clock, reset, enable
	input wire logic core_clk_i,
	input wire logic nrst_i,
	input wire logic ce_i,
	// spi pins
	input wire logic sclk_i,
	input wire logic cs_n_i,
	input wire logic mosi_i,
	output logic miso_o,
	output logic miso_oe_o,
	// rate samples in
	input wire logic raw_valid_i,
	input wire logic signed [iocr_pkg::RAW_W-1:0] raw_rate_i,
	// serial packet path
	output logic data_ready_o,
	output logic scaled_valid_o,
	output logic signed [iocr_pkg::WORD_W-1:0] scaled_rate_o,
	output logic rate_over_o,
	output logic [iocr_pkg::BYTE_W-1:0] filter_sel_o,
	output logic [iocr_pkg::WORD_W-1:0] axis_map_o,
	// low-level uart path
	output logic signed [iocr_pkg::RAW_W-1:0] uart_rate_o
);
	import iocr_pkg::*;

	localparam int BC_W = $clog2(BASE_CYC + 1);
	localparam logic [BC_W-1:0] BC_LAST = BC_W'(BASE_CYC - 1);

	// -----------------------------------------------------------------
	// state
	// -----------------------------------------------------------------
	typedef struct packed {
		logic sclk_q;
		logic cs_n_q;
		logic [CNT_W-1:0] bit_cnt;
		logic [WORD_W-1:0] rx_sh;
		logic [WORD_W-1:0] tx_sh;
		logic [WORD_W-1:0] tx_next;
		logic miso;
		logic miso_oe;
		logic [BYTE_W-1:0] rate_code;
		logic [BYTE_W-1:0] range_code;
		logic [BYTE_W-1:0] filt_code;
		logic [BYTE_W-1:0] rate_act;
		logic [BYTE_W-1:0] range_act;
		logic [BYTE_W-1:0] filt_act;
		logic [BYTE_W-1:0] map_hi;
		logic map_pend;
		logic [WORD_W-1:0] axis_map;
		logic [BC_W-1:0] base_cnt;
		logic [BYTE_W-1:0] div_cnt;
		logic drdy;
		logic scaled_valid;
		logic signed [WORD_W-1:0] scaled;
		logic over;
		logic signed [RAW_W-1:0] uart_raw;
	} iocr_state_t;

	iocr_state_t st;
	iocr_state_t next_st;

	// -----------------------------------------------------------------
	// reset release and pin synchronisers
	// -----------------------------------------------------------------
	logic rst_n;
	logic [2:0] pins_s;
	logic sclk_s;
	logic cs_n_s;
	logic mosi_s;

	// reset asserts at once but leaves in step with the clock
	iocr_sync #(
		.W(1),
		.INIT(1'b0)
	) u_rst_sync (
		.clk_i(core_clk_i),
		.rst_n_i(nrst_i),
		.en_i(1'b1),
		.d_i(1'b1),
		.q_o(rst_n)
	);

	// idle levels: clock high, select high; matching the edge
	// trackers' reset values keeps a false edge out after reset
	iocr_sync #(
		.W(3),
		.INIT(3'h6)
	) u_pin_sync (
		.clk_i(core_clk_i),
		.rst_n_i(rst_n),
		.en_i(ce_i),
		.d_i({sclk_i, cs_n_i, mosi_i}),
		.q_o(pins_s)
	);

	assign sclk_s = pins_s[2];
	assign cs_n_s = pins_s[1];
	assign mosi_s = pins_s[0];

	// -----------------------------------------------------------------
	// next-state logic
	// -----------------------------------------------------------------
	logic sclk_rise;
	logic sclk_fall;
	logic cs_fall;
	logic cs_rise;
	logic word_done;
	logic [WORD_W-1:0] word;
	logic wr_cmd;
	logic [ADDR_W-1:0] cmd_addr;
	logic [BYTE_W-1:0] cmd_data;
	logic base_tick;
	logic [BYTE_W-1:0] div;
	logic [2:0] shift;
	logic signed [RAW_W-1:0] mag;
	logic signed [RAW_W-1:0] lim;
	logic signed [RAW_W-1:0] clipped;
	logic signed [RAW_W-1:0] shifted;
	logic over_set;
	logic over_clr;

	// edges of the synchronised link signals
	always_comb begin
		sclk_rise = !st.sclk_q && sclk_s && !cs_n_s;
		sclk_fall = st.sclk_q && !sclk_s && !cs_n_s;
		cs_fall = st.cs_n_q && !cs_n_s;
		cs_rise = !st.cs_n_q && cs_n_s;
		word = {st.rx_sh[WORD_W-2:0], mosi_s};
		word_done = sclk_rise && (st.bit_cnt == LAST_BIT);
		wr_cmd = word[WORD_W-1];
		cmd_addr = word[WORD_W-2:BYTE_W];
		cmd_data = word[BYTE_W-1:0];
		base_tick = (st.base_cnt == BC_LAST);
	end

	// sample path: clip, over-range check and scaling
	// clip before the shift so the limit is exact in raw units
	always_comb begin
		shift = range_shift(st.range_act);
		mag = raw_rate_i[RAW_W-1] ? -raw_rate_i : raw_rate_i;
		lim = sig_lim(shift);
		over_set = raw_valid_i && (mag > ovr_lim(shift));
		if (raw_rate_i > lim) begin
			clipped = lim;
		end else if (raw_rate_i < -lim) begin
			clipped = -lim;
		end else begin
			clipped = raw_rate_i;
		end
		shifted = clipped >>> shift;
	end

	always_comb begin
		next_st = st;
		over_clr = 1'b0;
		div = rate_div(st.rate_code);
		next_st.drdy = 1'b0;
		next_st.scaled_valid = 1'b0;

		// link edge tracking
		next_st.sclk_q = sclk_s;
		next_st.cs_n_q = cs_n_s;

		// frame start: load reply, drive miso
		if (cs_fall) begin
			next_st.bit_cnt = '0;
			next_st.tx_sh = st.tx_next;
			next_st.miso_oe = 1'b1;
		end

		// leading (falling) edge shifts out, msb first
		if (sclk_fall) begin
			next_st.miso = st.tx_sh[WORD_W-1];
			next_st.tx_sh = {st.tx_sh[WORD_W-2:0], 1'b0};
		end

		// trailing (rising) edge samples mosi
		if (sclk_rise) begin
			next_st.rx_sh = word;
			next_st.bit_cnt = st.bit_cnt + 1'b1;
		end

		// frame end releases miso; a cut frame never reaches the
		// sixteenth rise, so its bits are simply dropped
		if (cs_rise) begin
			next_st.miso_oe = 1'b0;
			next_st.bit_cnt = '0;
		end

		// completed 16-bit command
		if (word_done) begin
			next_st.bit_cnt = '0;
			// any command other than a write of the high byte breaks a pair
			next_st.map_pend = 1'b0;
			if (wr_cmd) begin
				unique case (cmd_addr)
					ADDR_RATE: begin
						// code zero is legal and stops output
						if (rate_div(cmd_data) != '0 || cmd_data == '0) begin
							next_st.rate_code = cmd_data;
						end
					end
					ADDR_RANGE: begin
						if (range_shift(cmd_data) != 3'h7) begin
							next_st.range_code = cmd_data;
						end
					end
					ADDR_FILT: begin
						if (filt_ok(cmd_data)) begin
							next_st.filt_code = cmd_data;
						end
					end
					ADDR_MAP_HI: begin
						next_st.map_hi = cmd_data;
						next_st.map_pend = 1'b1;
					end
					ADDR_MAP_LO: begin
						if (st.map_pend) begin
							next_st.axis_map = {st.map_hi, cmd_data};
						end
					end
					default: begin
					end
				endcase
				next_st.tx_next = '0;
			end else begin
				// reply goes out in the next frame
				unique case (cmd_addr)
					ADDR_RATE: begin
						next_st.tx_next = {RST_RATE[WORD_W-1:BYTE_W],
							st.rate_code};
					end
					ADDR_FILT: begin
						next_st.tx_next = {RST_FILT[WORD_W-1:BYTE_W],
							st.filt_code};
					end
					ADDR_RANGE: begin
						// range code goes out in the high byte
						next_st.tx_next = {st.range_code,
							RST_RANGE[BYTE_W-1:0]};
					end
					ADDR_MAP_HI: begin
						next_st.tx_next = st.axis_map;
						next_st.map_pend = 1'b0;
					end
					ADDR_DIAG: begin
						// reading the diagnostic word clears the sticky flag
						next_st.tx_next = '0;
						next_st.tx_next[DIAG_OVER_BIT] = st.over;
						over_clr = 1'b1;
					end
					default: begin
						next_st.tx_next = '0;
					end
				endcase
			end
		end

		// base sample period counter; it runs even while output is
		// stopped, so a new rate always starts on a period boundary
		if (base_tick) begin
			next_st.base_cnt = '0;
		end else begin
			next_st.base_cnt = st.base_cnt + 1'b1;
		end

		// selections take effect at the period boundary
		if (base_tick) begin
			next_st.rate_act = st.rate_code;
			next_st.range_act = st.range_code;
			next_st.filt_act = st.filt_code;
			if (st.rate_code != st.rate_act) begin
				// new rate restarts pacing right away
				next_st.div_cnt = '0;
				next_st.drdy = (div != '0);
			end else if (div != '0) begin
				if (st.div_cnt + 1'b1 >= div) begin
					next_st.div_cnt = '0;
					next_st.drdy = 1'b1;
				end else begin
					next_st.div_cnt = st.div_cnt + 1'b1;
				end
			end
		end

		// sample path into packet and uart outputs
		if (raw_valid_i) begin
			next_st.uart_raw = raw_rate_i;
			next_st.scaled = shifted[WORD_W-1:0];
			next_st.scaled_valid = 1'b1;
		end

		// sticky over-range, a new event beats the read clear
		next_st.over = (st.over && !over_clr) || over_set;
	end

	// -----------------------------------------------------------------
	// state register
	// -----------------------------------------------------------------
	// ce_i low freezes every field, one-cycle pulses included
	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			st <= '0;
			st.sclk_q <= 1'b1;
			st.cs_n_q <= 1'b1;
			st.rate_code <= RST_RATE[BYTE_W-1:0];
			st.rate_act <= RST_RATE[BYTE_W-1:0];
			// the range default sits in the high byte of its reset word
			st.range_code <= RST_RANGE[WORD_W-1:BYTE_W];
			st.range_act <= RST_RANGE[WORD_W-1:BYTE_W];
			st.filt_code <= RST_FILT[BYTE_W-1:0];
			st.filt_act <= RST_FILT[BYTE_W-1:0];
			st.axis_map <= MAP_RESET;
		end else if (ce_i) begin
			st <= next_st;
		end
	end

	// -----------------------------------------------------------------
	// outputs, all straight from the state register
	// -----------------------------------------------------------------
	// miso keeps its last bit when released; miso_oe_o qualifies it
	assign miso_o = st.miso;
	assign miso_oe_o = st.miso_oe;
	assign data_ready_o = st.drdy;
	assign scaled_valid_o = st.scaled_valid;
	assign scaled_rate_o = st.scaled;
	assign rate_over_o = st.over;
	assign filter_sel_o = st.filt_act;
	assign axis_map_o = st.axis_map;
	assign uart_rate_o = st.uart_raw;
endmodule : iocr_regs

// file: testbench/iocr_spi_master.sv
/*
 * SPI master model for the output configuration bank: mode 3, 16-bit
 * words, msb first, 160 ns link clock. Assumes callers enter xfer on
 * a falling core clock edge.
 */
module iocr_spi_master (
	// core clock
	input wire logic clk_i,
	// spi pins
	output logic sclk_o,
	output logic cs_n_o,
	output logic mosi_o,
	input wire logic miso_i,
	input wire logic miso_oe_i
);
	timeunit 1ns;
	timeprecision 1ps;
	logic last;
	// idle: clock high, deselected
	initial begin
		sclk_o = 1'b1;
		cs_n_o = 1'b1;
		mosi_o = 1'b0;
		last = 1'b0;
	end
	// one frame out; reply bits in at each rising link edge
	task automatic xfer(input logic [15:0] w, output logic [15:0] r);
		cs_n_o = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			repeat (20) @(negedge clk_i);
			sclk_o = 1'b0;
			mosi_o = w[i];
			last = w[i];
			repeat (20) @(negedge clk_i);
			sclk_o = 1'b1;
			// an undriven line shows the inverse of the last bit
			r[i] = miso_oe_i ? miso_i : ~last;
		end
		repeat (20) @(negedge clk_i);
		cs_n_o = 1'b1;
		mosi_o = ~last;
		repeat (8) @(negedge clk_i);
	endtask : xfer
endmodule : iocr_spi_master

// file: testbench/iocr_regs_assertions.sv
/*
 * Port checker for the output configuration bank.
 * Assumes ce_i drops only for whole base periods, so base ticks
 * keep a fixed grid.
 */
module iocr_regs_checker
	import iocr_pkg::*;
#(
	parameter int BASE_CYC = iocr_pkg::BASE_CYCLES
) (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic nrst_i,
	// watched ports
	input wire logic cs_n_i,
	input wire logic raw_valid_i,
	input wire logic signed [iocr_pkg::RAW_W-1:0] raw_rate_i,
	input wire logic miso_oe_o,
	input wire logic data_ready_o,
	input wire logic scaled_valid_o,
	input wire logic signed [iocr_pkg::WORD_W-1:0] scaled_rate_o,
	input wire logic rate_over_o,
	input wire logic [iocr_pkg::BYTE_W-1:0] filter_sel_o,
	input wire logic [iocr_pkg::WORD_W-1:0] axis_map_o,
	input wire logic signed [iocr_pkg::RAW_W-1:0] uart_rate_o
);
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!nrst_i);
	int gap;
	logic seen;
	// cycles since the last data-ready pulse
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			gap <= 0;
			seen <= 1'b0;
		end else if (data_ready_o) begin
			gap <= 0;
			seen <= 1'b1;
		end else begin
			gap <= gap + 1;
		end
	end
	a_oe_idle: assert property (cs_n_i [*6] |-> !miso_oe_o)
		else $error("miso driven while deselected");
	a_oe_busy: assert property (!cs_n_i [*6] |-> miso_oe_o)
		else $error("miso not driven while selected");
	a_valid_next: assert property (raw_valid_i |=> scaled_valid_o)
		else $error("scaled sample missing");
	a_valid_cause: assert property (scaled_valid_o |-> $past(raw_valid_i))
		else $error("scaled sample without input");
	a_uart_copy: assert property (raw_valid_i |=>
		uart_rate_o == $past(raw_rate_i)) else $error("uart copy altered");
	a_over_set: assert property (raw_valid_i && (raw_rate_i > 20'sh40740
		|| raw_rate_i < -20'sh40740) |=> rate_over_o)
		else $error("over-range flag not set");
	a_over_cause: assert property ($rose(rate_over_o) |-> $past(raw_valid_i))
		else $error("over-range flag rose without sample");
	a_sign_kept: assert property (scaled_valid_o |->
		scaled_rate_o[15] == $past(raw_rate_i[19]))
		else $error("scaled sign differs from raw");
	a_drdy_pulse: assert property (data_ready_o |=> !data_ready_o)
		else $error("data-ready wider than one cycle");
	a_drdy_grid: assert property (data_ready_o && seen |->
		(gap + 1) % BASE_CYC == 0) else $error("data-ready off tick grid");
	a_filter_defined: assert property (filter_sel_o inside {8'h00, 8'h03,
		8'h04, 8'h05, 8'h06, 8'h30, 8'h40, 8'h50, 8'h60})
		else $error("undefined filter code in force");
	a_map_idle: assert property (cs_n_i [*8] |-> $stable(axis_map_o))
		else $error("axis map changed outside a frame");
endmodule : iocr_regs_checker

bind iocr_regs iocr_regs_checker #(.BASE_CYC(BASE_CYC)) iocr_regs_checker_i (
	.core_clk_i, .nrst_i, .cs_n_i, .raw_valid_i, .raw_rate_i, .miso_oe_o,
	.data_ready_o, .scaled_valid_o, .scaled_rate_o, .rate_over_o,
	.filter_sel_o, .axis_map_o, .uart_rate_o);

// file: testbench/iocr_regs_test.sv
/*
 * Self-checking bench of the output configuration bank.
 * Assumes the SPI master model and a shortened base tick of 50 cycles.
 */
module iocr_regs_test;
	timeunit 1ns;
	timeprecision 1ps;
	import iocr_pkg::*;
	localparam int BASE = 50;
	logic core_clk = 1'b0;
	logic nrst = 1'b0;
	logic ce = 1'b1;
	logic raw_valid = 1'b0;
	logic signed [RAW_W-1:0] raw_rate = '0;
	logic sclk, cs_n, mosi, miso, miso_oe, drdy, sval, over;
	logic signed [WORD_W-1:0] scaled;
	logic [BYTE_W-1:0] filt, hi, lo;
	logic [WORD_W-1:0] amap, v, rsp;
	logic signed [RAW_W-1:0] uart;
	logic [31:0] seed = 32'h1536;
	int err_count = 0;
	int n_compared = 0;
	int n, k;
	logic [7:0] rcode [5] = '{8'h02, 8'h03, 8'h05, 8'h10, 8'h01};
	int rdiv [5] = '{2, 4, 10, 200, 1};
	logic [7:0] gcode [5] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10};
	int clip [5] = '{32000, 64000, 80000, 160000, 240000};
	int ovl [5] = '{25000, 50000, 88000, 176000, 264000};
	logic [7:0] fcode [9] = '{8'h00, 8'h03, 8'h04, 8'h05, 8'h06, 8'h30,
		8'h40, 8'h50, 8'h60};
	always #2 core_clk = ~core_clk;
	// ----------------------------------------------------------------
	// design and partner
	// ----------------------------------------------------------------
	iocr_regs #(.BASE_CYC(BASE)) iocr_regs_i (.core_clk_i(core_clk),
		.nrst_i(nrst), .ce_i(ce), .sclk_i(sclk), .cs_n_i(cs_n),
		.mosi_i(mosi), .miso_o(miso), .miso_oe_o(miso_oe),
		.raw_valid_i(raw_valid), .raw_rate_i(raw_rate),
		.data_ready_o(drdy), .scaled_valid_o(sval), .scaled_rate_o(scaled),
		.rate_over_o(over), .filter_sel_o(filt), .axis_map_o(amap),
		.uart_rate_o(uart));
	iocr_spi_master iocr_spi_master_i (.clk_i(core_clk), .sclk_o(sclk),
		.cs_n_o(cs_n), .mosi_o(mosi), .miso_i(miso), .miso_oe_i(miso_oe));
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	function automatic int exp_sc(input int raw, input int i);
		int c;
		c = (raw > clip[i]) ? clip[i] : (raw < -clip[i]) ? -clip[i] : raw;
		return c >>> i;
	endfunction : exp_sc
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_count++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic print_verdict();
		$display("compared %0d mismatched %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : print_verdict
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		iocr_spi_master_i.xfer({1'b1, a, d}, rsp);
	endtask : wr
	// read reply arrives in the following frame
	task automatic rd(input logic [6:0] a, output logic [15:0] q);
		iocr_spi_master_i.xfer({1'b0, a, 8'h00}, rsp);
		iocr_spi_master_i.xfer(16'h0000, q);
	endtask : rd
	task automatic wait_drdy(output int c);
		c = 0;
		do begin
			@(negedge core_clk);
			c++;
		end while (drdy !== 1'b1 && c < 12000);
		if (c >= 12000) check(0, 1);
	endtask : wait_drdy
	// one sample, checked when its scaled copy stands
	task automatic smp(input int raw, input int i);
		raw_valid = 1'b1;
		raw_rate = raw[19:0];
		@(negedge core_clk);
		raw_valid = 1'b0;
		check(sval, 1);
		check(scaled, exp_sc(raw, i));
		check(uart, raw);
		@(negedge core_clk);
	endtask : smp
	// ----------------------------------------------------------------
	// tests
	// ----------------------------------------------------------------
	initial begin
		#360000;
		err_count++;
		print_verdict();
	end
	initial begin
		repeat (4) @(negedge core_clk);
		nrst = 1'b1;
		repeat (8) @(negedge core_clk);
		check(filt, 8'h06);
		check(amap, RST_MAP);
		rd(ADDR_RATE, v);
		check(v, 16'h0101);
		rd(ADDR_FILT, v);
		check(v, 16'h0206);
		rd(ADDR_RANGE, v);
		check(v, 16'h0206);
		rd(7'h10, v);
		check(v, 16'h0000);
		smp(-50000, 1);
		$display("test reset done");
		// rate stop, undefined code, then paced codes
		wr(ADDR_RATE, 8'h00);
		repeat (100) @(negedge core_clk);
		k = 0;
		repeat (1000) @(negedge core_clk) if (drdy === 1'b1) k++;
		check(k, 0);
		wr(ADDR_RATE, 8'h0a);
		rd(ADDR_RATE, v);
		check(v, 16'h0100);
		foreach (rcode[i]) begin
			wr(ADDR_RATE, rcode[i]);
			wait_drdy(n);
			wait_drdy(n);
			check(n, rdiv[i] * BASE);
			rd(ADDR_RATE, v);
			check(v, {8'h01, rcode[i]});
		end
		// a low clock enable holds the pacing where it stands;
		// 100 frozen cycles are two whole base periods
		wait_drdy(n);
		@(negedge core_clk);
		ce = 1'b0;
		k = 0;
		repeat (100) @(negedge core_clk) if (drdy === 1'b1) k++;
		check(k, 0);
		ce = 1'b1;
		wait_drdy(n);
		check(n, BASE - 1);
		$display("test rate done");
		foreach (gcode[i]) begin
			wr(ADDR_RANGE, gcode[i]);
			wait_drdy(n);
			wait_drdy(n);
			rd(ADDR_RANGE, v);
			check(v, {gcode[i], 8'h06});
			rd(ADDR_DIAG, v);
			check(v, (i > 0) ? 16'h0010 : 16'h0000);
			smp(ovl[i], i);
			repeat (4) smp(int'(rnd() % (2 * ovl[i] + 1)) - ovl[i], i);
			check(over, 0);
			smp(-ovl[i] - 1, i);
			check(over, 1);
			smp(300000, i);
			smp(-300000, i);
		end
		wr(ADDR_RANGE, 8'h03);
		rd(ADDR_RANGE, v);
		check(v, 16'h1006);
		$display("test range done");
		foreach (fcode[i]) begin
			wr(ADDR_FILT, fcode[i]);
			wait_drdy(n);
			wait_drdy(n);
			check(filt, fcode[i]);
			rd(ADDR_FILT, v);
			check(v, {8'h02, fcode[i]});
		end
		wr(ADDR_FILT, 8'h07);
		wait_drdy(n);
		wait_drdy(n);
		check(filt, 8'h60);
		$display("test filter done");
		hi = 8'(rnd()) | 8'h01;
		lo = 8'(rnd()) | 8'h01;
		wr(ADDR_MAP_LO, lo);
		check(amap, RST_MAP);
		wr(ADDR_MAP_HI, hi);
		iocr_spi_master_i.xfer({1'b0, ADDR_MAP_HI, 8'h00}, rsp);
		wr(ADDR_MAP_LO, lo);
		check(amap, RST_MAP);
		wr(ADDR_MAP_HI, hi);
		wr(ADDR_RATE, 8'h01);
		wr(ADDR_MAP_LO, lo);
		check(amap, RST_MAP);
		wr(ADDR_MAP_HI, hi);
		wr(ADDR_MAP_LO, lo);
		check(amap, {hi, lo});
		rd(ADDR_MAP_HI, v);
		check(v, {hi, lo});
		$display("test orientation done");
		print_verdict();
	end
endmodule : iocr_regs_test
